// ==== rtl/strxc_channel.sv ====
// The implementer's own choices: the register offsets and register access over Avalon-MM.
module strxc_channel
    import strxc_pkg::*;
#(
    parameter int WIDTH = 20,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        pll_locked_ref,
    input  wire logic        reflection_seen,
    output logic             tx_serial,
    output logic             tx_elec_idle,
    output logic             detect_pulse,
    output logic             rx_pll_powerdown,
    output logic             clock_recovery_unit_powerdown,
    output logic             data_locked,
    output logic             ref_locked,
    output logic [2:0]       pll_mult_sel
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0] ctrl_r;
    logic [15:0] ppm_thr_r;
    logic [15:0] freq_err_r;
    logic        ack_r;
    logic        present_r;
    logic        det_done_r;
    logic [1:0]  ref_sync_r;
    logic [1:0]  refl_sync_r;

    // Control decode
    wire       pipe_mode   = ctrl_r[CTRL_PIPE_BIT];
    wire       force_idle  = ctrl_r[CTRL_IDLE_BIT];
    wire       detect_req  = ctrl_r[CTRL_DETECT_BIT];
    wire       chan_used   = ctrl_r[CTRL_USED_BIT];
    wire       force_ref   = ctrl_r[CTRL_REFLOCK_BIT];
    wire       force_data  = ctrl_r[CTRL_DATALOCK_BIT];
    wire [1:0] width_code  = ctrl_r[CTRL_WIDTH_LSB +: 2];
    wire [2:0] mult_code   = ctrl_r[CTRL_MULT_LSB +: 3];
    wire [4:0] word_len    = strxc_word_len(width_code);

    // Lock mode selection, data override has priority
    wire strxc_lock_type lock_mode = force_data ? LOCK_DATA :
                                     (force_ref ? LOCK_REF : LOCK_AUTO);

    // ------------------------------------------------------------
    // Avalon-MM slave: one wait state on every access except a data write to a full FIFO, which waits until the FIFO has room
    // ------------------------------------------------------------
    wire access   = (avs_read || avs_write) && !ack_r;
    wire wr_ctrl  = avs_write && ack_r && (avs_address == ADDR_CTRL);
    wire wr_data  = avs_write && ack_r && (avs_address == ADDR_TXDATA);
    wire wr_ppm   = avs_write && ack_r && (avs_address == ADDR_PPM);
    wire wr_freq  = avs_write && ack_r && (avs_address == ADDR_FREQ);

    // FIFO between the bus and the serializer
    strxc_stream_if #(.WIDTH(WIDTH)) fill_s ();
    strxc_stream_if #(.WIDTH(WIDTH)) drain_s ();

    // Writes to a full FIFO stall the bus rather than drop words
    wire data_stall = (avs_address == ADDR_TXDATA) && avs_write && !fill_s.ready;
    assign fill_s.valid = wr_data;
    assign fill_s.data  = avs_writedata[WIDTH-1:0];

    strxc_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
        .clk     (clk),
        .reset_n (reset_n),
        .in_s    (fill_s),
        .out_s   (drain_s)
    );

    // ------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------
    logic        state_data;
    wire [31:0] status_word = {24'h0, present_r, det_done_r, !drain_s.valid, !fill_s.ready,
                               tx_elec_idle, ref_locked, data_locked, state_data};

    wire [31:0] rd_mux = (avs_address == ADDR_CTRL)   ? ctrl_r :
                         (avs_address == ADDR_STATUS) ? status_word :
                         (avs_address == ADDR_PPM)    ? {16'h0, ppm_thr_r} :
                         (avs_address == ADDR_FREQ)   ? {16'h0, freq_err_r} :
                         (avs_address == ADDR_TXDATA) ? 32'h0 : UNMAPPED_VALUE;

    // Handshake: request seen, answer next edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_r           <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= '0;
        end else begin
            ack_r           <= access && !data_stall;
            avs_waitrequest <= !(access && !data_stall);
            if (avs_read && !ack_r) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    // Software registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r     <= CTRL_RESET;
            ppm_thr_r  <= PPM_RESET;
            freq_err_r <= '1;
        end else begin
            if (wr_ctrl) ctrl_r <= avs_writedata;
            if (wr_ppm)  ppm_thr_r <= avs_writedata[15:0];
            if (wr_freq) freq_err_r <= avs_writedata[15:0];
            if (det_done_r && detect_req && !detect_pulse) ctrl_r[CTRL_DETECT_BIT] <= wr_ctrl ?
                avs_writedata[CTRL_DETECT_BIT] : 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_sync_r  <= '0;
            refl_sync_r <= '0;
        end else begin
            ref_sync_r  <= {ref_sync_r[0], pll_locked_ref};
            refl_sync_r <= {refl_sync_r[0], reflection_seen};
        end
    end

    // ------------------------------------------------------------
    // Clock recovery lock state
    // ------------------------------------------------------------
    wire in_ppm = (freq_err_r <= ppm_thr_r);
    wire data_nxt = !chan_used ? 1'b0 :
                    (lock_mode == LOCK_DATA) ? 1'b1 :
                    (lock_mode == LOCK_REF)  ? 1'b0 :
                    (state_data ? in_ppm : (ref_sync_r[1] && in_ppm));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_data                    <= 1'b0;
            data_locked                   <= 1'b0;
            ref_locked                    <= 1'b0;
            rx_pll_powerdown              <= 1'b1;
            clock_recovery_unit_powerdown <= 1'b1;
            pll_mult_sel                  <= '0;
        end else begin
            state_data                    <= data_nxt;
            data_locked                   <= data_nxt;
            ref_locked                    <= chan_used && !data_nxt && ref_sync_r[1];
            rx_pll_powerdown              <= !chan_used;
            clock_recovery_unit_powerdown <= !chan_used;
            pll_mult_sel                  <= mult_code;
        end
    end

    // ------------------------------------------------------------
    // Receiver detect sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {DET_IDLE, DET_PULSE, DET_DONE} strxc_det_type;
    strxc_det_type det_r;
    logic [7:0]    det_cnt_r;
    wire           det_start = detect_req && pipe_mode && !det_done_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            det_r        <= DET_IDLE;
            det_cnt_r    <= '0;
            detect_pulse <= 1'b0;
            det_done_r   <= 1'b0;
            present_r    <= 1'b0;
        end else begin
            case (det_r)
                DET_IDLE: begin
                    // Done flag stands for software until a new request is written
                    if (wr_ctrl && avs_writedata[CTRL_DETECT_BIT]) det_done_r <= 1'b0;
                    if (det_start) begin
                        det_r        <= DET_PULSE;
                        det_cnt_r    <= 8'(DETECT_CYCLES - 1);
                        detect_pulse <= 1'b1;
                    end
                end
                DET_PULSE: begin
                    if (det_cnt_r == '0) begin
                        detect_pulse <= 1'b0;
                        present_r    <= refl_sync_r[1];
                        det_r        <= DET_DONE;
                    end else begin
                        det_cnt_r <= det_cnt_r - 1'b1;
                    end
                end
                DET_DONE: begin
                    det_done_r <= 1'b1;
                    det_r      <= DET_IDLE;
                end
                default: det_r <= DET_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Serializer, LSB first
    // ------------------------------------------------------------
    logic [WIDTH-1:0] shift_r;
    logic [4:0]       bits_left_r;
    wire  idle_now = pipe_mode && (force_idle || det_r != DET_IDLE || det_start);
    wire  load     = (bits_left_r <= 5'd1) && drain_s.valid && !idle_now;
    assign drain_s.ready = load;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            shift_r      <= '0;
            bits_left_r  <= '0;
            tx_serial    <= 1'b0;
            tx_elec_idle <= 1'b1;
        end else begin
            tx_elec_idle <= idle_now || (bits_left_r <= 5'd1 && !drain_s.valid);
            if (load) begin
                tx_serial   <= drain_s.data[0];
                shift_r     <= drain_s.data >> 1;
                bits_left_r <= word_len;
            end else if (bits_left_r > 5'd1 && !idle_now) begin
                tx_serial   <= shift_r[0];
                shift_r     <= shift_r >> 1;
                bits_left_r <= bits_left_r - 1'b1;
            end else begin
                tx_serial <= 1'b0;
                if (!idle_now) bits_left_r <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_lock_priority: assert property (@(posedge clk) disable iff (!reset_n)
        chan_used && force_data && $stable(ctrl_r) |=> data_locked) else $error("data override ignored");
    chk_ref_override: assert property (@(posedge clk) disable iff (!reset_n)
        chan_used && !force_data && force_ref |=> !data_locked) else $error("ref override ignored");
    chk_auto_ppm: assert property (@(posedge clk) disable iff (!reset_n)
        !force_data && !force_ref && !in_ppm |=> !data_locked) else $error("data lock outside ppm");
    chk_idle_pipe: assert property (@(posedge clk) disable iff (!reset_n)
        pipe_mode && force_idle |=> tx_elec_idle) else $error("force idle not honoured");
    chk_detect_idle: assert property (@(posedge clk) disable iff (!reset_n)
        detect_pulse |-> tx_elec_idle && pipe_mode) else $error("detect without idle");
    chk_powerdown: assert property (@(posedge clk) disable iff (!reset_n)
        !chan_used ##1 !chan_used |-> rx_pll_powerdown && clock_recovery_unit_powerdown)
        else $error("unused channel powered");
    chk_data_flag: assert property (@(posedge clk) disable iff (!reset_n)
        data_locked == state_data) else $error("data lock flag mismatch");
    chk_ref_flag: assert property (@(posedge clk) disable iff (!reset_n)
        ref_locked |-> !data_locked && $past(ref_sync_r[1])) else $error("ref lock without pll");
    chk_serial_lsb: assert property (@(posedge clk) disable iff (!reset_n)
        load |=> tx_serial == $past(drain_s.data[0])) else $error("first bit not lsb");
    chk_mult_static: assert property (@(posedge clk) disable iff (!reset_n)
        $stable(mult_code) |=> pll_mult_sel == $past(mult_code)) else $error("mult select wrong");
endmodule

// ==== rtl/strxc_pkg.sv ====
package strxc_pkg;
    // ------------------------------------------------------------
    // Register map (word offsets as byte addresses)
    // ------------------------------------------------------------
    localparam logic [4:0]  ADDR_CTRL      = 5'h00;
    localparam logic [4:0]  ADDR_STATUS    = 5'h04;
    localparam logic [4:0]  ADDR_TXDATA    = 5'h08;
    localparam logic [4:0]  ADDR_PPM       = 5'h0c;
    localparam logic [4:0]  ADDR_FREQ      = 5'h10;
    localparam logic [31:0] UNMAPPED_VALUE = 32'hdeadbeef;

    // ------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------
    localparam int CTRL_PIPE_BIT    = 0;
    localparam int CTRL_IDLE_BIT    = 1;
    localparam int CTRL_DETECT_BIT  = 2;
    localparam int CTRL_USED_BIT    = 3;
    localparam int CTRL_REFLOCK_BIT = 4;
    localparam int CTRL_DATALOCK_BIT = 5;
    localparam int CTRL_WIDTH_LSB   = 8;
    localparam int CTRL_MULT_LSB    = 12;

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
    localparam logic [15:0] PPM_RESET       = 16'h0010;
    localparam int          CLK_MHZ         = 25;
    localparam int          DETECT_PULSE_NS = 400;
    localparam int          DETECT_CYCLES   = (DETECT_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int          FIFO_DEPTH      = 8;

    // Word widths and lock modes
    typedef enum logic [1:0] {W8, W10, W16, W20} strxc_width_type;
    typedef enum logic [1:0] {LOCK_AUTO, LOCK_REF, LOCK_DATA} strxc_lock_type;

    // Serial word length for a width code
    function automatic logic [4:0] strxc_word_len(input logic [1:0] code);
        case (code)
            2'h0:    strxc_word_len = 5'd8;
            2'h1:    strxc_word_len = 5'd10;
            2'h2:    strxc_word_len = 5'd16;
            default: strxc_word_len = 5'd20;
        endcase
    endfunction

    // Supported multiplication factors 1,4,5,8,10,16,20,25 by code
    function automatic logic [4:0] strxc_mult(input logic [2:0] code);
        case (code)
            3'h0:    strxc_mult = 5'd1;
            3'h1:    strxc_mult = 5'd4;
            3'h2:    strxc_mult = 5'd5;
            3'h3:    strxc_mult = 5'd8;
            3'h4:    strxc_mult = 5'd10;
            3'h5:    strxc_mult = 5'd16;
            3'h6:    strxc_mult = 5'd20;
            default: strxc_mult = 5'd25;
        endcase
    endfunction
endpackage

// ==== rtl/strxc_stream_if.sv ====
interface strxc_stream_if #(parameter int WIDTH = 20);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface

// ==== rtl/strxc_fifo.sv ====
module strxc_fifo
    import strxc_pkg::*;
#(
    parameter int WIDTH = 20,
    parameter int DEPTH = 8
) (
    input  wire logic   clk,
    input  wire logic   reset_n,
    strxc_stream_if.dst in_s,
    strxc_stream_if.src out_s
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;

    // ------------------------------------------------------------
    // Handshake decode
    // ------------------------------------------------------------
    wire push = in_s.valid && in_s.ready;
    wire pop  = out_s.valid && out_s.ready;

    assign in_s.ready  = (count_r != (AW+1)'(DEPTH));
    assign out_s.valid = (count_r != '0);
    assign out_s.data  = mem_r[rd_ptr_r];

    // Storage, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_s.data;
        end
    end

    // Pointers wrap at the depth, which may not be a power of two
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    chk_no_overflow: assert property (@(posedge clk) disable iff (!reset_n)
        count_r <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

// ==== dv/strxc_far_model.sv ====
module strxc_far_model (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       tx_serial,
    input  wire logic       tx_elec_idle,
    input  wire logic       detect_pulse,
    input  wire logic       rx_pll_powerdown,
    input  wire logic       lock_en,
    input  wire logic [4:0] word_len,
    output logic            pll_locked_ref,
    output logic            reflection_seen
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [19:0] shift_r = 20'h0;
    int          cnt_r = 0;
    logic [19:0] rx_q[$];

    // ------------------------------------------------------------
    // Remote receiver
    // ------------------------------------------------------------
    // Bits gathered LSB first; idle restarts framing, so a stray bit cannot shift words
    always @(posedge clk) begin
        if (!reset_n || tx_elec_idle) begin
            cnt_r = 0;
        end else begin
            shift_r = {tx_serial, shift_r[19:1]};
            cnt_r++;
            if (cnt_r == int'(word_len)) begin
                rx_q.push_back(shift_r >> (20 - int'(word_len)));
                cnt_r = 0;
            end
        end
    end

    // A powered-down PLL never reports lock
    assign pll_locked_ref = lock_en && !rx_pll_powerdown;
    // Reflection only when the line is tri-stated during the pulse
    assign reflection_seen = detect_pulse && tx_elec_idle;
endmodule

// ==== dv/strxc_channel_tb_top.sv ====
module strxc_channel_tb_top
    import strxc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        pll_locked_ref;
    logic        reflection_seen;
    logic        tx_serial;
    logic        tx_elec_idle;
    logic        detect_pulse;
    logic        rx_pll_powerdown;
    logic        clock_recovery_unit_powerdown;
    logic        data_locked;
    logic        ref_locked;
    logic [2:0]  pll_mult_sel;
    logic        lock_en = 1'b0;
    logic [4:0]  word_len = 5'h14;
    logic [31:0] q;
    int          errors = 0;
    int          cmp_count = 0;
    int          cyc = 0;

    // 25 MHz clock
    always #20 clk = ~clk;

    strxc_channel i_strxc_channel (
        .clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .pll_locked_ref, .reflection_seen,
        .tx_serial, .tx_elec_idle, .detect_pulse, .rx_pll_powerdown,
        .clock_recovery_unit_powerdown, .data_locked, .ref_locked, .pll_mult_sel
    );

    strxc_far_model i_strxc_far_model (
        .clk, .reset_n, .tx_serial, .tx_elec_idle, .detect_pulse,
        .rx_pll_powerdown, .lock_en, .word_len, .pll_locked_ref, .reflection_seen
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Hang guard; the full run needs about a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            summarize();
        end
    end

    // One bus cycle; a fresh edge first so strobes never toggle twice in a step
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 200);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n == 200) check(32'h1, 32'h0);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(q & m, exp);
    endtask

    task automatic take_word(input logic [19:0] exp);
        int n;
        n = 0;
        while (i_strxc_far_model.rx_q.size() == 0 && n < 200) begin
            @(posedge clk);
            n++;
        end
        if (n == 200) check(32'h1, 32'h0);
        else check(32'(i_strxc_far_model.rx_q.pop_front()), 32'(exp));
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check(32'({rx_pll_powerdown, clock_recovery_unit_powerdown}), 32'h3);
        check(32'({tx_elec_idle, data_locked, ref_locked}), 32'h4);
        rd(ADDR_CTRL, 32'hffff_ffff, 32'h0);
        rd(ADDR_PPM, 32'hffff, 32'h10);
        bus(1'b1, 5'h14, 32'hffff_ffff);
        rd(5'h14, 32'hffff_ffff, UNMAPPED_VALUE);
        rd(ADDR_CTRL, 32'hffff_ffff, 32'h0);
    endtask

    // Ten words per width back to back; the serializer drains meanwhile, so the eight-word buffer just fills at widths 16 and 20 and no write stalls
    task automatic t_serial();
        int lens[4] = '{8, 10, 16, 20};
        logic [19:0] msk;
        for (int w = 0; w < 4; w++) begin
            word_len <= 5'(lens[w]);
            msk = 20'((32'h1 << lens[w]) - 1);
            bus(1'b1, ADDR_CTRL, 32'h8 | (w << 8));
            for (int k = 0; k < 10; k++) bus(1'b1, ADDR_TXDATA, 32'h5a3c1 + k * 32'h1357 + w);
            for (int k = 0; k < 10; k++) take_word(20'(32'h5a3c1 + k * 32'h1357 + w) & msk);
            rd(ADDR_STATUS, 32'h30, 32'h20);
        end
    endtask

    task automatic t_idle();
        int hi;
        hi = 0;
        word_len <= 5'h14;
        bus(1'b1, ADDR_CTRL, 32'h30b);
        bus(1'b1, ADDR_TXDATA, 32'h9c3a5);
        repeat (30) @(posedge clk) hi += int'(tx_elec_idle === 1'b1);
        check(32'(hi), 32'd30);
        bus(1'b1, ADDR_CTRL, 32'h309);
        take_word(20'h9c3a5);
        // Force idle outside PIPE mode has no effect
        bus(1'b1, ADDR_CTRL, 32'h30a);
        bus(1'b1, ADDR_TXDATA, 32'h1e2d3);
        take_word(20'h1e2d3);
    endtask

    task automatic t_detect();
        int hi;
        int bad;
        hi = 0;
        bad = 0;
        bus(1'b1, ADDR_CTRL, 32'h0c);
        repeat (30) @(posedge clk) hi += int'(detect_pulse === 1'b1);
        check(32'(hi), 32'h0);
        bus(1'b1, ADDR_CTRL, 32'h0d);
        repeat (40) @(posedge clk) begin
            hi += int'(detect_pulse === 1'b1);
            bad += int'(detect_pulse === 1'b1 && tx_elec_idle !== 1'b1);
        end
        check(32'(hi), 32'(DETECT_CYCLES));
        check(32'(bad), 32'h0);
        rd(ADDR_STATUS, 32'hc0, 32'hc0);
        rd(ADDR_CTRL, 32'h4, 32'h0);
    endtask

    // Override bits, freq error, PLL lock, expected data and ref lock
    task automatic t_lock();
        logic [31:0] tab[6] = '{32'h00_010_1_2, 32'h00_011_1_1, 32'h00_005_0_0,
                                 32'h10_005_1_1, 32'h20_0ff_0_2, 32'h30_011_1_2};
        foreach (tab[i]) begin
            lock_en <= tab[i][4];
            bus(1'b1, ADDR_FREQ, 32'(tab[i][19:8]));
            bus(1'b1, ADDR_CTRL, 32'h8 | 32'(tab[i][27:20]));
            repeat (12) @(posedge clk);
            check(32'({data_locked, ref_locked}), 32'(tab[i][1:0]));
            rd(ADDR_STATUS, 32'h6, 32'({tab[i][0], tab[i][1], 1'b0}));
        end
    endtask

    task automatic t_power();
        for (int m = 0; m < 8; m++) begin
            bus(1'b1, ADDR_CTRL, (m << 12) | ((m & 1) << 3));
            repeat (3) @(posedge clk);
            check(32'(pll_mult_sel), 32'(m));
            check(32'({rx_pll_powerdown, clock_recovery_unit_powerdown}), (m & 1) ? 32'h0 : 32'h3);
        end
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_serial();
        t_idle();
        t_detect();
        t_lock();
        t_power();
        summarize();
    end
endmodule
